/* File: hw/spp_put_unit.sv */
// What this block does
// - Source register word goes out on the link chosen by instruction bits 0-3.
// - A link number at or above the configured count falls back to link zero.
// - Dynamic form takes the link from the low four bits of rB.
// - Four independent option bits give sixteen variants of each form.
// - Blocking form stalls until the chosen link has room, then writes.
// - Non-blocking form never stalls; carry cleared with room, set without.
// - Control sideband is low for data writes, high for control writes.
// - Test-only forms behave normally but never raise the write strobe.
// - Atomic forms keep interrupts out; exceptions still allowed.
// - With memory management, user mode without permission raises cause 00111.
// - Unstalled write takes one cycle, or two in area-optimized build.
// - Static blocking stall serves interrupts only with extended ops and non-atomic.
// - Dynamic blocking stall serves interrupts unless atomic.
// - Test and atomic forms exist only with extended ops enabled.
// - Needs at least one link; dynamic form also needs extended ops.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`include "spp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module spp_put_unit
	import spp_pkg::*;
#(
	parameter int unsigned CONFIGURED_LINK_COUNT = 4,
	parameter bit EXTENDED_STREAM_OPS_ENABLE = 1'b1,
	parameter bit AREA_OPTIMIZED_OPTION = 1'b0,
	parameter bit MEMORY_MANAGEMENT_OPTION = 1'b0,
	parameter bit USER_STREAM_ACCESS_ALLOW = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Instruction issue from the core
	input wire logic issue_valid,
	input wire spp_word_t issue_instr,
	input wire spp_word_t issue_src_a,
	input wire spp_word_t issue_src_b,
	input wire logic user_mode_flag,
	input wire logic irq_pending,
	input wire logic other_retire,
	// Results to the core
	output logic put_done_r,
	output logic stall_r,
	output logic carry_we_r,
	output logic carry_status_flag_r,
	output logic exc_r,
	output logic [4:0] exception_cause_field_r,
	output logic irq_serve_r,
	output logic irq_block_r,
	// Outbound stream links
	output spp_word_t link_out_word_r,
	output logic link_out_ctrl_bit_r,
	output logic [`SPP_MAX_LINKS-1:0] link_out_wr_r,
	input wire logic [`SPP_MAX_LINKS-1:0] link_out_no_room,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire spp_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output spp_word_t reg_rdata_r,
	output logic irq_r
);

	localparam int LAT_CYC = AREA_OPTIMIZED_OPTION ? `SPP_LAT_AREA : `SPP_LAT_PERF;
	localparam bit HAVE_LINKS = CONFIGURED_LINK_COUNT > 0;
	localparam bit EXT = EXTENDED_STREAM_OPS_ENABLE;
	localparam logic [4:0] LINK_CNT = 5'(CONFIGURED_LINK_COUNT);

	spp_state_e state_r;
	spp_state_e state_nxt;
	spp_opt_t opt_h_r;
	spp_link_t raw_h_r;
	logic dyn_h_r;
	spp_word_t word_h_r;
	spp_link_t last_link_r;
	logic [3:0] status_r;
	logic [3:0] mask_r;
	logic irq_block_nxt;

	spp_link_t eff_link;
	logic [`SPP_MAX_LINKS-1:0] link_hot;
	logic room;

	wire in_idle = (state_r == st_idle);
	wire in_area = (state_r == st_area);
	wire in_wait = (state_r == st_wait);

	wire [5:0] opc = issue_instr[31:26];
	wire is_stat = issue_valid && opc == `SPP_OPC_STATIC && issue_instr[`SPP_S_MARK];
	wire is_dyn = issue_valid && opc == `SPP_OPC_DYN && issue_instr[`SPP_D_MARK];
	wire [3:0] s_opt = issue_instr[`SPP_S_OPT_LSB +: 4];
	wire [3:0] d_opt = issue_instr[`SPP_D_OPT_LSB +: 4];
	wire [3:0] dec_opt = is_dyn ? d_opt : s_opt;
	wire [3:0] dec_raw = is_dyn ? issue_src_b[3:0] : issue_instr[3:0];
	wire dec_ext = dec_opt[`SPP_OPT_TEST] || dec_opt[`SPP_OPT_ATOM];

	wire ext_ok = !dec_ext || EXT;
	wire form_ok = HAVE_LINKS && (!is_dyn || EXT);
	wire dec_legal = form_ok && ext_ok;
	wire dec_priv = MEMORY_MANAGEMENT_OPTION && !USER_STREAM_ACCESS_ALLOW && user_mode_flag;

	wire take = in_idle && (is_stat || is_dyn);
	wire take_bad = take && !dec_legal;
	wire take_priv = take && dec_legal && dec_priv;
	wire take_ok = take && dec_legal && !dec_priv;
	wire take_exc = take_bad || take_priv;

	// The held copy is used once the instruction has left the issue cycle.
	wire [3:0] cur_opt = in_idle ? dec_opt : opt_h_r;
	wire [3:0] cur_raw = in_idle ? dec_raw : raw_h_r;
	wire cur_dyn = in_idle ? is_dyn : dyn_h_r;
	wire spp_word_t cur_word = in_idle ? issue_src_a : word_h_r;
	wire cur_nb = cur_opt[`SPP_OPT_NB];
	wire cur_ctrl = cur_opt[`SPP_OPT_CTRL];
	wire cur_test = cur_opt[`SPP_OPT_TEST];
	wire cur_atom = cur_opt[`SPP_OPT_ATOM];

	spp_link_sel #(
		.LINK_COUNT(CONFIGURED_LINK_COUNT)
	) u_sel (
		.raw_link(cur_raw),
		.no_room(link_out_no_room),
		.eff_link(eff_link),
		.link_hot(link_hot),
		.room(room)
	);

	wire att_en = (take_ok && !AREA_OPTIMIZED_OPTION) || in_area || in_wait;

	wire stat_irq_ok = !cur_dyn && EXT && !cur_atom;
	wire dyn_irq_ok = cur_dyn && !cur_atom;
	wire abort = in_wait && (stat_irq_ok || dyn_irq_ok) && irq_pending && !room;

	wire complete = att_en && (room || cur_nb);
	wire to_wait = att_en && !complete && !abort;
	wire do_write = complete && room && !cur_test;
	wire nb_done = complete && cur_nb;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			st_idle: begin
				if (take_ok && AREA_OPTIMIZED_OPTION) begin
					state_nxt = st_area;
				end else if (take_ok && to_wait) begin
					state_nxt = st_wait;
				end
			end
			st_area: begin
				state_nxt = to_wait ? st_wait : st_idle;
			end
			st_wait: begin
				if (complete || abort) begin
					state_nxt = st_idle;
				end
			end
			default: begin
				state_nxt = st_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= st_idle;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			opt_h_r <= 4'h0;
			raw_h_r <= 4'h0;
			dyn_h_r <= 1'b0;
			word_h_r <= 32'h0;
		end else if (take_ok) begin
			opt_h_r <= dec_opt;
			raw_h_r <= dec_raw;
			dyn_h_r <= is_dyn;
			word_h_r <= issue_src_a;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			link_out_wr_r <= 16'h0000;
			link_out_word_r <= 32'h0;
		end else begin
			link_out_wr_r <= do_write ? link_hot : 16'h0000;
			if (do_write) begin
				link_out_word_r <= cur_word;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			link_out_ctrl_bit_r <= 1'b0;
			last_link_r <= 4'h0;
		end else if (complete) begin
			link_out_ctrl_bit_r <= cur_ctrl;
			last_link_r <= eff_link;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			put_done_r <= 1'b0;
			stall_r <= 1'b0;
			carry_we_r <= 1'b0;
			carry_status_flag_r <= 1'b0;
		end else begin
			put_done_r <= complete;
			stall_r <= (state_nxt == st_wait);
			carry_we_r <= nb_done;
			if (nb_done) begin
				carry_status_flag_r <= !room;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			exc_r <= 1'b0;
			exception_cause_field_r <= 5'h00;
		end else begin
			exc_r <= take_exc;
			if (take_exc) begin
				exception_cause_field_r <= take_bad ? `SPP_EC_ILLEGAL : `SPP_EC_PRIV;
			end
		end
	end

	always_comb begin
		irq_block_nxt = irq_block_r;
		if (state_nxt != st_idle) begin
			irq_block_nxt = cur_atom || (!cur_dyn && !EXT);
		end else if (complete) begin
			irq_block_nxt = cur_atom;
		end else if (abort || take_exc || other_retire) begin
			irq_block_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_block_r <= 1'b0;
			irq_serve_r <= 1'b0;
		end else begin
			irq_block_r <= irq_block_nxt;
			irq_serve_r <= abort;
		end
	end

	// Register port decode; a status bit set by hardware wins over a clear.
	wire [3:0] ev;
	assign ev[`SPP_EV_DONE] = complete;
	assign ev[`SPP_EV_NOROOM] = nb_done && !room;
	assign ev[`SPP_EV_EXC] = take_exc;
	assign ev[`SPP_EV_IRQ] = abort;

	wire wr_status = reg_wr && reg_addr == `SPP_OFF_STATUS;
	wire wr_mask = reg_wr && reg_addr == `SPP_OFF_MASK;
	wire [3:0] clr_bits = wr_status ? reg_wdata[3:0] : 4'h0;
	wire [3:0] status_nxt = (status_r & ~clr_bits) | ev;
	wire [3:0] mask_nxt = wr_mask ? reg_wdata[3:0] : mask_r;
	wire spp_word_t info = {25'h0, irq_block_r, stall_r, link_out_ctrl_bit_r, last_link_r};
	wire spp_word_t rd_mux =
		(reg_addr == `SPP_OFF_STATUS) ? {28'h0, status_r} :
		(reg_addr == `SPP_OFF_MASK) ? {28'h0, mask_r} :
		(reg_addr == `SPP_OFF_INFO) ? info : 32'h0;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			status_r <= `SPP_RST_STATUS;
			mask_r <= `SPP_RST_MASK;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= |(status_nxt & mask_nxt);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata_r <= 32'h0;
		end else begin
			reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	a_strobe_one_hot: assert property (
		|link_out_wr_r |-> $onehot(link_out_wr_r) && $past(do_write)
	) else $error("link strobe not one-hot or without a write");

	a_link_fallback: assert property (
		att_en && ({1'b0, cur_raw} >= LINK_CNT) |-> eff_link == 4'h0
	) else $error("out of range link not redirected to link zero");

	a_dyn_link_pick: assert property (
		take_ok && is_dyn && ({1'b0, issue_src_b[3:0]} < LINK_CNT)
		|-> ##1 raw_h_r == $past(issue_src_b[3:0])
	) else $error("dynamic link number not taken from rB");

	a_block_stall: assert property (
		att_en && !cur_nb && !room && !abort |=> stall_r && !put_done_r && link_out_wr_r == 16'h0000
	) else $error("blocking put completed without room");

	a_nb_carry: assert property (
		att_en && cur_nb |=> carry_we_r && put_done_r && !stall_r && carry_status_flag_r == !$past(room)
	) else $error("non-blocking carry wrong");

	a_ctrl_follow: assert property (
		complete |=> link_out_ctrl_bit_r == $past(cur_ctrl)
	) else $error("control bit does not follow the option");

	a_test_no_strobe: assert property (
		att_en && cur_test |=> link_out_wr_r == 16'h0000
	) else $error("test-only put raised the strobe");

	a_atomic_no_irq: assert property (
		in_wait && cur_atom |-> !abort ##1 irq_block_r
	) else $error("atomic put open to interrupts");

	a_priv_cause: assert property (
		take_priv |=> exc_r && exception_cause_field_r == `SPP_EC_PRIV && !put_done_r
	) else $error("privileged put did not raise cause 00111");

	a_put_latency: assert property (
		take_ok && dec_opt[`SPP_OPT_NB] |-> ##[LAT_CYC:LAT_CYC] put_done_r
	) else $error("unstalled put latency wrong");

endmodule
`default_nettype wire

/* File: hw/spp_defs.svh */
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH

// Register byte offsets on the plain register port.
`define SPP_OFF_STATUS 4'h0
`define SPP_OFF_MASK 4'h4
`define SPP_OFF_INFO 4'h8

// Event bit positions in the status and mask registers.
`define SPP_EV_DONE 0
`define SPP_EV_NOROOM 1
`define SPP_EV_EXC 2
`define SPP_EV_IRQ 3

// Reset values.
`define SPP_RST_STATUS 4'h0
`define SPP_RST_MASK 4'h0

// Instruction decode: major opcodes and the marker bit of each form.
`define SPP_OPC_STATIC 6'h1B
`define SPP_OPC_DYN 6'h13
`define SPP_S_MARK 15
`define SPP_D_MARK 10

// Low end of the four option bits, and each option inside that field.
`define SPP_S_OPT_LSB 11
`define SPP_D_OPT_LSB 6
`define SPP_OPT_NB 3
`define SPP_OPT_CTRL 2
`define SPP_OPT_TEST 1
`define SPP_OPT_ATOM 0

// Exception cause codes.
`define SPP_EC_PRIV 5'h07
`define SPP_EC_ILLEGAL 5'h01

// Cycles from issue to completion without a stall.
`define SPP_LAT_PERF 1
`define SPP_LAT_AREA 2

// Number of link ports at the boundary.
`define SPP_MAX_LINKS 16

`endif

/* File: hw/spp_pkg.sv */
package spp_pkg;

	typedef enum {st_idle, st_area, st_wait} spp_state_e;

	typedef logic [31:0] spp_word_t;
	typedef logic [3:0] spp_link_t;
	typedef logic [3:0] spp_opt_t;

endpackage

/* File: hw/spp_link_sel.sv */
`include "spp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module spp_link_sel
	import spp_pkg::*;
#(
	parameter int unsigned LINK_COUNT = 4
) (
	// Requested link
	input wire spp_link_t raw_link,
	// Room indications of all links
	input wire logic [`SPP_MAX_LINKS-1:0] no_room,
	// Selection result
	output spp_link_t eff_link,
	output logic [`SPP_MAX_LINKS-1:0] link_hot,
	output logic room
);

	localparam logic [4:0] LINK_CNT = 5'(LINK_COUNT);

	assign eff_link = ({1'b0, raw_link} >= LINK_CNT) ? 4'h0 : raw_link;

	genvar i;
	generate
		for (i = 0; i < `SPP_MAX_LINKS; i++) begin : g_link
			assign link_hot[i] = (eff_link == 4'(i));
		end
	endgenerate

	assign room = !no_room[eff_link];

endmodule
`default_nettype wire

/* File: testbench/spp_sink_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spp_sink_model
	import spp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Back-pressure commanded by the bench
	input wire logic [15:0] hold_full,
	// Link side
	input wire spp_word_t link_out_word_r,
	input wire logic link_out_ctrl_bit_r,
	input wire logic [15:0] link_out_wr_r,
	output logic [15:0] link_out_no_room,
	// Observation
	output int unsigned cap_count,
	output int unsigned drop_count,
	output spp_word_t last_word,
	output logic last_ctrl
);
	assign link_out_no_room = hold_full;

	// capture when not full
	// A strobe into a full link is lost, exactly as a real queue would lose it.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cap_count <= 0;
			drop_count <= 0;
		end else if (link_out_wr_r != 16'h0) begin
			if ((link_out_wr_r & link_out_no_room) != 16'h0) begin
				drop_count <= drop_count + 1;
			end else begin
				cap_count <= cap_count + 1;
				last_word <= link_out_word_r;
				last_ctrl <= link_out_ctrl_bit_r;
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/test_stream_put_port.sv */
`include "spp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module test_stream_put_port
	import spp_pkg::*;
;
	logic ref_clk, sys_rst, issue_valid, user_mode_flag, irq_pending, other_retire;
	spp_word_t issue_instr, issue_src_a, issue_src_b, reg_wdata, reg_rdata_r, link_out_word_r;
	spp_word_t last_word, wv;
	logic put_done_r, stall_r, carry_we_r, carry_status_flag_r, exc_r, irq_serve_r;
	logic irq_block_r, link_out_ctrl_bit_r, reg_wr, reg_rd, irq_r, last_ctrl;
	logic [4:0] exception_cause_field_r;
	logic [15:0] link_out_wr_r, link_out_no_room, hold_full;
	logic [3:0] reg_addr, eff, lk;
	int unsigned cap_count, drop_count, ncap;
	int bad_count, tests_run, lat, saw_stall;

	spp_put_unit #(.CONFIGURED_LINK_COUNT(4), .MEMORY_MANAGEMENT_OPTION(1'b1)) uut (
		.ref_clk, .sys_rst, .issue_valid, .issue_instr, .issue_src_a, .issue_src_b,
		.user_mode_flag, .irq_pending, .other_retire, .put_done_r, .stall_r, .carry_we_r,
		.carry_status_flag_r, .exc_r, .exception_cause_field_r, .irq_serve_r, .irq_block_r,
		.link_out_word_r, .link_out_ctrl_bit_r, .link_out_wr_r, .link_out_no_room,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .irq_r);

	spp_sink_model sink (.ref_clk, .sys_rst, .hold_full, .link_out_word_r,
		.link_out_ctrl_bit_r, .link_out_wr_r, .link_out_no_room, .cap_count,
		.drop_count, .last_word, .last_ctrl);

	function automatic spp_word_t sop(logic [3:0] o, logic [3:0] l);
		return {6'h1B, 10'h0, 1'b1, o, 7'h0, l};
	endfunction

	function automatic spp_word_t dop(logic [3:0] o);
		return {6'h13, 15'h0, 1'b1, o, 6'h0};
	endfunction

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Ends with the answer cycle sampled; lat counts cycles spent stalled.
	task issue(input spp_word_t ins, input spp_word_t a, input spp_word_t b);
		@(posedge ref_clk);
		issue_valid <= 1'b1;
		issue_instr <= ins;
		issue_src_a <= a;
		issue_src_b <= b;
		@(posedge ref_clk);
		issue_valid <= 1'b0;
		lat = 0;
		saw_stall = 0;
		#1;
		while (!(put_done_r | exc_r | irq_serve_r)) begin
			saw_stall |= (stall_r === 1'b1);
			if (lat == 60) begin
				chk("answer_wait", 0, 1);
				test_done;
			end
			@(posedge ref_clk);
			#1;
			lat++;
		end
	endtask

	task rw(input logic [3:0] a, input spp_word_t d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task rr(input string nm, input logic [3:0] a, input spp_word_t e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata_r, e);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		{sys_rst, issue_valid, user_mode_flag, irq_pending, other_retire} = 5'h10;
		{issue_instr, issue_src_a, issue_src_b, reg_wdata} = '0;
		{reg_addr, reg_wr, reg_rd, hold_full} = '0;
		bad_count = 0;
		tests_run = 0;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("idle_strobe", link_out_wr_r, 0);
		// Every option pattern of both forms, links 15 down to 0.
		for (int f = 0; f < 2; f++) begin
			for (int i = 0; i < 16; i++) begin
				lk = 4'(15 - i);
				eff = (lk >= 4) ? 4'h0 : lk;
				ncap = cap_count;
				wv = 32'h5A00_0000 + 32'(i * 257 + f);
				if (f == 0)
					issue(sop(4'(i), lk), wv, 32'h0);
				else
					issue(dop(4'(i)), wv, {28'hABCDEF0, lk});
				chk("latency", lat, 0);
				chk("done", put_done_r, 1);
				chk("ctrl", link_out_ctrl_bit_r, i[2]);
				chk("strobe", link_out_wr_r, i[1] ? 0 : 16'h1 << eff);
				chk("carry_we", carry_we_r, i[3]);
				if (i[3]) chk("carry_room", carry_status_flag_r, 0);
				if (!i[1]) chk("word", link_out_word_r, wv);
				@(posedge ref_clk);
				#1;
				chk("irq_block", irq_block_r, i[0]);
				chk("captured", cap_count, ncap + 32'(!i[1]));
				if (!i[1]) chk("sink_word", last_word, wv);
				if (!i[1]) chk("sink_ctrl", last_ctrl, i[2]);
			end
		end
		@(posedge ref_clk) hold_full <= 16'h0004;
		fork
			issue(sop(4'h0, 4'h2), 32'h1234_5678, 32'h0);
			begin
				repeat (6) @(posedge ref_clk);
				hold_full <= 16'h0002;
			end
		join
		chk("stalled", saw_stall, 1);
		chk("stall_len", lat >= 4, 1);
		chk("late_strobe", link_out_wr_r, 16'h0004);
		issue(sop(4'h8, 4'h1), 32'h0, 32'h0);
		chk("nb_latency", lat, 0);
		chk("carry_full", carry_status_flag_r, 1);
		chk("nb_strobe", link_out_wr_r, 0);
		// Blocking stalls with an interrupt waiting: both forms, plain and atomic.
		// Link 1 starts full each round; only the atomic puts live to see the release.
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk) irq_pending <= 1'b1;
			hold_full <= 16'h0002;
			fork
				begin
					issue(k[1] ? dop(4'(k[0])) : sop(4'(k[0]), 4'h1), 32'h77, 32'h1);
					chk("served", irq_serve_r, !k[0]);
					chk("atomic_done", put_done_r, k[0]);
				end
				begin
					repeat (8) @(posedge ref_clk);
					hold_full <= 16'h0000;
				end
			join
			@(posedge ref_clk) irq_pending <= 1'b0;
		end
		chk("block_held", irq_block_r, 1);
		rr("info", `SPP_OFF_INFO, 32'h41);
		@(posedge ref_clk) other_retire <= 1'b1;
		@(posedge ref_clk) other_retire <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("block_end", irq_block_r, 0);
		@(posedge ref_clk) user_mode_flag <= 1'b1;
		issue(dop(4'h0), 32'h99, 32'h0);
		chk("priv", exc_r, 1);
		chk("cause", exception_cause_field_r, 5'h07);
		chk("priv_strobe", link_out_wr_r, 0);
		@(posedge ref_clk) user_mode_flag <= 1'b0;
		rr("status", `SPP_OFF_STATUS, 32'hF);
		rw(`SPP_OFF_MASK, 32'h4);
		@(posedge ref_clk);
		#1;
		chk("irq_on", irq_r, 1);
		rr("mask", `SPP_OFF_MASK, 32'h4);
		rw(`SPP_OFF_STATUS, 32'hB);
		rr("status_w1c", `SPP_OFF_STATUS, 32'h4);
		chk("irq_kept", irq_r, 1);
		rw(`SPP_OFF_STATUS, 32'h4);
		@(posedge ref_clk);
		#1;
		chk("irq_off", irq_r, 0);
		rw(4'hC, 32'hFFFF_FFFF);
		rr("unmapped", 4'hC, 32'h0);
		rr("mask_kept", `SPP_OFF_MASK, 32'h4);
		chk("drops", drop_count, 0);
		test_done;
	end
endmodule
`default_nettype wire
